// File: src/sfi_id_reader.sv
// Identification readout engine of a serial flash: ID, unique number,
// standard ID and parameter table reads, plus a report to the system clock.
// Assumes SCK idles low while CS_N is high (mode 0) and stops between frames.
//
// Functional notes
// - Opcode 90h, zero address, then manufacturer then device ID, MSB first.
// - Address bit zero set swaps order: device ID first, then manufacturer.
// - ID bytes alternate while clocking continues; chip select high ends it.
// - Opcode 92h takes address two bits per clock, returns IDs two bits.
// - Opcode 94h: four dummy clocks then address four bits per clock.
// - Quad ID read returns IDs four bits per clock, MSB first.
// - Opcode 4Bh: four dummy bytes, then 64-bit unique number out.
// - Opcode 9Fh returns manufacturer, memory type, capacity bytes in order.
// - Opcode 5Ah: address, eight dummies, data from fortieth falling edge.
// - Table start byte comes from address bits 7 to 0.
// - Table bytes 0-3 signature, bytes 4 and 5 read 01h.
// - Byte 6 holds header count minus one; byte 7 reads FFh.
// - Byte 8 manufacturer code, bytes 9 and 0Ah revision 1.0.
// - Byte 0Bh length four, bytes 0Ch-0Eh pointer 000080h low first.
//
// Clock domains
// The frame logic runs on SCK alone: rising edges take the opcode, address,
// dummy and mode bits, and falling edges launch the readout lanes.
// Chip select high clears both SCK halves at once, so a cut frame leaves
// nothing behind for the next opcode to trip over.
// The MCLK side synchronises only a level for an active readout and a toggle per opcode.
// The opcode word itself is held in the SCK domain and read by MCLK only
// after its toggle has passed two flops, long after the word settled.
//
// Limitations
// Counts saturate at 127 rises, so every start point must stay below that.
// Mode bits of the dual and quad forms are clocked in but never looked at.
// Only address bit 0 matters to the ID forms, and bits 7 to 0 to the table.
// The table holds the first header only; every other byte reads all ones.
// A host that keeps SCK running with chip select high sees nothing change,
// since both frame processes are held in their cleared state.
//
// Trade-offs
// Byte and bit selection is combinational from the output count, which
// keeps the falling-edge process short at the cost of a deeper lane path.
// The report toggle is reset by RESET only, so an opcode that arrives just
// before chip select rises is still reported once.

`timescale 1ns/1ps

module sfi_id_reader #(
   // Identity values; all defaults are arbitrary
   parameter logic [7:0] MFR_ID = 8'h5c,
   parameter logic [7:0] DEV_ID = 8'h13,
   parameter logic [7:0] MEM_TYPE = 8'h40,
   parameter logic [7:0] CAPACITY = 8'h15,
   parameter logic [63:0] UNIQUE_ID = 64'h0123456789abcdef
) (
   input wire logic MCLK,
   input wire logic RESET,
   input wire logic SCK,
   input wire logic CS_N,
   input wire logic [3:0] IO_IN,
   output logic [3:0] IO_OUT,
   output logic [3:0] IO_OE_N,
   output logic ID_ACTIVE,
   output logic CMD_STROBE,
   output logic [7:0] CMD_CODE,
   output logic CMD_KNOWN
);

   logic [6:0] cnt_q;
   logic [6:0] cnt_d;
   logic [7:0] opc_q;
   logic [23:0] addr_q;
   logic [10:0] ocnt_q;
   logic [3:0] io_q;
   logic [3:0] oe_n_q;
   logic act_q;
   logic tog_q;
   logic [7:0] code_q;

   // Opcode decode, valid once eight clocks are in
   // Before that the partial opcode can match 4Bh or 5Ah, since only its
   // leading bit is still a cleared zero, so its uses are gated by opc_done
   wire opc_done = cnt_q >= sfi_pkg::CNT_OPC_END;
   wire is_sgl = opc_q == sfi_pkg::OPC_ID_SINGLE;
   wire is_dual = opc_q == sfi_pkg::OPC_ID_DUAL;
   wire is_quad = opc_q == sfi_pkg::OPC_ID_QUAD;
   wire is_uid = opc_q == sfi_pkg::OPC_UNIQUE;
   wire is_std = opc_q == sfi_pkg::OPC_STD_ID;
   wire is_par = opc_q == sfi_pkg::OPC_PARAM;
   wire is_id = is_sgl | is_dual | is_quad;
   wire known = is_id | is_uid | is_std | is_par;

   // Address windows per instruction
   // Counts are the rises already taken, so a window [a, b) covers rises a+1 to b
   // The table read shares the single-lane window with the single ID read
   wire win_sgl = (is_sgl | is_par) & opc_done & (cnt_q < sfi_pkg::CNT_SGL_ADDR_END);
   wire win_dual = is_dual & opc_done & (cnt_q < sfi_pkg::CNT_DUAL_ADDR_END);
   wire win_quad = is_quad & (cnt_q >= sfi_pkg::CNT_QUAD_DUMMY_END)
      & (cnt_q < sfi_pkg::CNT_QUAD_ADDR_END);

   // Start of the data phase
   // The first drive happens at the fall that follows rise start_cnt, so the
   // host sees the first bit at the next rise
   wire [6:0] start_cnt = is_sgl ? sfi_pkg::START_ID_SINGLE :
      is_dual ? sfi_pkg::START_ID_DUAL :
      is_quad ? sfi_pkg::START_ID_QUAD :
      is_uid ? sfi_pkg::START_UNIQUE :
      is_std ? sfi_pkg::START_STD_ID : sfi_pkg::START_PARAM;
   wire data_phase = opc_done & known & (cnt_q >= start_cnt);

   // Byte index in the output stream, by lane width
   // Quad spends two falls per byte, dual four and single eight
   wire [7:0] byte_idx = is_quad ? ocnt_q[8:1] : is_dual ? ocnt_q[9:2] : ocnt_q[10:3];

   // Parameter table lookup; unlisted bytes read as all ones
   function automatic logic [7:0] table_byte(input logic [7:0] a);
      logic [7:0] v;
      v = sfi_pkg::PT_UNUSED;
      unique case (a)
         8'h00: v = sfi_pkg::PT_SIGNATURE[7:0];
         8'h01: v = sfi_pkg::PT_SIGNATURE[15:8];
         8'h02: v = sfi_pkg::PT_SIGNATURE[23:16];
         8'h03: v = sfi_pkg::PT_SIGNATURE[31:24];
         8'h04: v = sfi_pkg::PT_REV_MINOR;
         8'h05: v = sfi_pkg::PT_REV_MAJOR;
         8'h06: v = sfi_pkg::PT_HDR_COUNT_M1;
         8'h07: v = sfi_pkg::PT_RESERVED;
         8'h08: v = MFR_ID;
         8'h09: v = sfi_pkg::PT_BASICS_MINOR;
         8'h0a: v = sfi_pkg::PT_BASICS_MAJOR;
         8'h0b: v = sfi_pkg::PT_BASICS_LEN;
         8'h0c: v = sfi_pkg::PT_BASICS_PTR[7:0];
         8'h0d: v = sfi_pkg::PT_BASICS_PTR[15:8];
         8'h0e: v = sfi_pkg::PT_BASICS_PTR[23:16];
         default: v = sfi_pkg::PT_UNUSED;
      endcase
      return v;
   endfunction

   // Byte selection per instruction
   // ID bytes alternate with the low index bit, flipped by address bit 0
   // The unique number goes out most significant byte first and repeats
   // The table index wraps at 256 since the sum is kept to eight bits
   wire id_swap = byte_idx[0] ^ addr_q[0];
   wire [7:0] id_byte = id_swap ? DEV_ID : MFR_ID;
   wire [5:0] uid_sh = {~byte_idx[2:0], 3'b000};
   wire [63:0] uid_shifted = UNIQUE_ID >> uid_sh;
   wire [7:0] uid_byte = uid_shifted[7:0];
   wire [7:0] std_byte = (byte_idx == 8'h00) ? MFR_ID :
      (byte_idx == 8'h01) ? MEM_TYPE :
      (byte_idx == 8'h02) ? CAPACITY : sfi_pkg::PT_UNUSED;
   wire [7:0] par_addr = addr_q[7:0] + byte_idx;
   wire [7:0] cur_byte = is_id ? id_byte : is_uid ? uid_byte :
      is_std ? std_byte : table_byte(par_addr);

   // Bit lanes, MSB first
   // Single mode drives the serial output lane only, so enables read 4'hd
   wire [2:0] bit_off = is_quad ? {ocnt_q[0], 2'b00} :
      is_dual ? {ocnt_q[1:0], 1'b0} : ocnt_q[2:0];
   wire [7:0] sh_byte = cur_byte << bit_off;
   wire [3:0] io_d = is_quad ? sh_byte[7:4] :
      is_dual ? {2'b00, sh_byte[7:6]} :
      {2'b00, sh_byte[7], 1'b0};
   wire [3:0] oe_n_d = is_quad ? 4'h0 : is_dual ? 4'hc : 4'hd;

   assign cnt_d = (cnt_q == sfi_pkg::CNT_MAX) ? cnt_q : cnt_q + 7'h01;

   // Input side; chip select high clears the frame state
   // The opcode stops shifting once eight bits are in, which freezes the decode
   // for the rest of the frame
   always_ff @(posedge SCK or posedge CS_N)
   begin
      if (CS_N)
      begin
         cnt_q <= 7'h00;
         opc_q <= 8'h00;
         addr_q <= 24'h000000;
      end
      else
      begin
         cnt_q <= cnt_d;
         if (!opc_done)
            opc_q <= {opc_q[6:0], IO_IN[0]};
         if (win_sgl)
            addr_q <= {addr_q[22:0], IO_IN[0]};
         else if (win_dual)
            addr_q <= {addr_q[21:0], IO_IN[1:0]};
         else if (win_quad)
            addr_q <= {addr_q[19:0], IO_IN[3:0]};
      end
   end

   // Output side on falling edges; released at once when chip select rises
   // Unknown opcodes never reach the data phase, so the lanes stay released
   always_ff @(negedge SCK or posedge CS_N)
   begin
      if (CS_N)
      begin
         io_q <= sfi_pkg::IO_IDLE;
         oe_n_q <= sfi_pkg::OE_N_IDLE;
         ocnt_q <= 11'h000;
         act_q <= 1'b0;
      end
      else if (data_phase)
      begin
         io_q <= io_d;
         oe_n_q <= oe_n_d;
         ocnt_q <= ocnt_q + 11'h001;
         act_q <= 1'b1;
      end
   end

   assign IO_OUT = io_q;
   assign IO_OE_N = oe_n_q;

   // Opcode report; survives chip select so the toggle is never lost
   // The eighth rise is caught while cnt_q still reads seven, and the word is
   // built from the incoming bit so it is complete at that same edge
   always_ff @(posedge SCK or posedge RESET)
   begin
      if (RESET)
      begin
         tog_q <= 1'b0;
         code_q <= 8'h00;
      end
      else if (!CS_N && cnt_q == sfi_pkg::CNT_OPC_END - 7'h01)
      begin
         tog_q <= ~tog_q;
         code_q <= {opc_q[6:0], IO_IN[0]};
      end
   end

   logic [1:0] act_s_q;
   logic [2:0] tog_s_q;
   logic strobe_q;
   logic [7:0] code_m_q;
   logic known_q;

   // Crossings into MCLK: level for activity, toggle for each opcode
   // The activity chain feeds on from its second flop, the toggle chain from its second and third
   always_ff @(posedge MCLK or posedge RESET)
   begin
      if (RESET)
      begin
         act_s_q <= 2'b00;
         tog_s_q <= 3'b000;
      end
      else
      begin
         act_s_q <= {act_s_q[0], act_q};
         tog_s_q <= {tog_s_q[1:0], tog_q};
      end
   end

   // Opcode word is stable long before its toggle arrives
   // Opcodes must be spaced by a few MCLK periods, or a toggle pair cancels
   wire tog_edge = tog_s_q[2] ^ tog_s_q[1];
   wire code_known = (code_q == sfi_pkg::OPC_ID_SINGLE) | (code_q == sfi_pkg::OPC_ID_DUAL)
      | (code_q == sfi_pkg::OPC_ID_QUAD) | (code_q == sfi_pkg::OPC_UNIQUE)
      | (code_q == sfi_pkg::OPC_STD_ID) | (code_q == sfi_pkg::OPC_PARAM);

   // Strobe, code and known flag leave together, all from flops
   always_ff @(posedge MCLK or posedge RESET)
   begin
      if (RESET)
      begin
         strobe_q <= 1'b0;
         code_m_q <= 8'h00;
         known_q <= 1'b0;
      end
      else
      begin
         strobe_q <= tog_edge;
         if (tog_edge)
         begin
            code_m_q <= code_q;
            known_q <= code_known;
         end
      end
   end

   // Report outputs, registered in the MCLK domain
   assign ID_ACTIVE = act_s_q[1];
   assign CMD_STROBE = strobe_q;
   assign CMD_CODE = code_m_q;
   assign CMD_KNOWN = known_q;

endmodule

// File: pkg/sfi_pkg.sv
// Constants for the identification readout logic of a serial flash.
// Assumes SPI mode 0 framing: inputs sampled on rising edges, outputs on falling edges.
package sfi_pkg;

   // Instruction codes
   localparam logic [7:0] OPC_ID_SINGLE = 8'h90;
   localparam logic [7:0] OPC_ID_DUAL = 8'h92;
   localparam logic [7:0] OPC_ID_QUAD = 8'h94;
   localparam logic [7:0] OPC_UNIQUE = 8'h4b;
   localparam logic [7:0] OPC_STD_ID = 8'h9f;
   localparam logic [7:0] OPC_PARAM = 8'h5a;

   // Clock counts, counted as rising edges since chip select fell
   localparam logic [6:0] CNT_OPC_END = 7'h08;
   localparam logic [6:0] CNT_SGL_ADDR_END = 7'h20;
   localparam logic [6:0] CNT_DUAL_ADDR_END = 7'h14;
   localparam logic [6:0] CNT_QUAD_DUMMY_END = 7'h0c;
   localparam logic [6:0] CNT_QUAD_ADDR_END = 7'h12;
   localparam logic [6:0] CNT_MAX = 7'h7f;

   // First falling edge that drives data, as a rising edge count
   localparam logic [6:0] START_ID_SINGLE = 7'h20;
   localparam logic [6:0] START_ID_DUAL = 7'h18;
   localparam logic [6:0] START_ID_QUAD = 7'h14;
   localparam logic [6:0] START_UNIQUE = 7'h28;
   localparam logic [6:0] START_STD_ID = 7'h08;
   localparam logic [6:0] START_PARAM = 7'h28;

   // Parameter table contents
   localparam logic [31:0] PT_SIGNATURE = 32'h50444653;
   localparam logic [7:0] PT_REV_MINOR = 8'h01;
   localparam logic [7:0] PT_REV_MAJOR = 8'h01;
   localparam logic [7:0] PT_HDR_COUNT_M1 = 8'h00;
   localparam logic [7:0] PT_RESERVED = 8'hff;
   localparam logic [7:0] PT_BASICS_MINOR = 8'h00;
   localparam logic [7:0] PT_BASICS_MAJOR = 8'h01;
   localparam logic [7:0] PT_BASICS_LEN = 8'h04;
   localparam logic [23:0] PT_BASICS_PTR = 24'h000080;
   localparam logic [7:0] PT_UNUSED = 8'hff;

   // Reset values
   localparam logic [3:0] OE_N_IDLE = 4'hf;
   localparam logic [3:0] IO_IDLE = 4'h0;

endpackage

// File: dv/sfi_id_reader_props.sv
// Port checker for the identification readout engine, bound into it.
// Assumes mode 0 frames: SCK stands low while CS_N is high.
`timescale 1ns/1ps
module sfi_id_reader_props (
   input wire logic MCLK,
   input wire logic RESET,
   input wire logic SCK,
   input wire logic CS_N,
   input wire logic [3:0] IO_IN,
   input wire logic [3:0] IO_OE_N,
   input wire logic ID_ACTIVE
);
   logic [6:0] cnt_q, cnt_d;
   logic [7:0] opc_q, opc_d;
   // Saturating rise count since chip select fell, and the opcode shifted in
   assign cnt_d = (cnt_q == 7'h7f) ? cnt_q : cnt_q + 7'h01;
   assign opc_d = (cnt_q < 7'h08) ? {opc_q[6:0], IO_IN[0]} : opc_q;
   // Cleared by chip select, like the frame logic it shadows
   always_ff @(posedge SCK or posedge CS_N)
      if (CS_N) {cnt_q, opc_q} <= 15'h0000;
      else {cnt_q, opc_q} <= {cnt_d, opc_d};
   // Enables seen at a fall were set one fall earlier, hence count above start
   AST_SGL_START: assert property (@(negedge SCK) disable iff (CS_N)
      opc_q == 8'h90 |-> IO_OE_N == (cnt_q > 7'h20 ? 4'hd : 4'hf)) else $error("90h lanes");
   AST_DUAL_START: assert property (@(negedge SCK) disable iff (CS_N)
      opc_q == 8'h92 |-> IO_OE_N == (cnt_q > 7'h18 ? 4'hc : 4'hf)) else $error("92h lanes");
   AST_QUAD_START: assert property (@(negedge SCK) disable iff (CS_N)
      opc_q == 8'h94 |-> IO_OE_N == (cnt_q > 7'h14 ? 4'h0 : 4'hf)) else $error("94h lanes");
   AST_UID_START: assert property (@(negedge SCK) disable iff (CS_N)
      opc_q == 8'h4b |-> IO_OE_N == (cnt_q > 7'h28 ? 4'hd : 4'hf)) else $error("4bh lanes");
   AST_STD_START: assert property (@(negedge SCK) disable iff (CS_N)
      opc_q == 8'h9f |-> IO_OE_N == (cnt_q > 7'h08 ? 4'hd : 4'hf)) else $error("9fh lanes");
   AST_TBL_START: assert property (@(negedge SCK) disable iff (CS_N)
      opc_q == 8'h5a |-> IO_OE_N == (cnt_q > 7'h28 ? 4'hd : 4'hf)) else $error("5ah lanes");
   AST_OPC_QUIET: assert property (@(negedge SCK) disable iff (CS_N)
      cnt_q < 7'h09 |-> IO_OE_N == 4'hf) else $error("drove during opcode");
   AST_ACTIVE_END: assert property (@(posedge MCLK) disable iff (RESET)
      $rose(CS_N) |-> ##[0:5] !ID_ACTIVE) else $error("readout flag stuck");
endmodule
bind sfi_id_reader sfi_id_reader_props chk (.MCLK, .RESET, .SCK, .CS_N, .IO_IN, .IO_OE_N, .ID_ACTIVE);

// File: dv/sfi_host.sv
// SPI host model: runs identification frames and collects the bytes read back.
// Assumes mode 0; SCK runs only inside frames, with a 48 ns period.
`timescale 1ns/1ps
module sfi_host (
   output logic SCK,
   output logic CS_N,
   output logic [3:0] IO_IN,
   input wire logic [3:0] IO_OUT,
   input wire logic [3:0] IO_OE_N
);
   logic [3:0] hv = 4'h0;
   logic hoe = 1'b0;
   logic [127:0] rx;
   // Released lanes show the host drive, or its inverse once the host stops driving, so stale data never passes
   assign IO_IN = (~IO_OE_N & IO_OUT) | (IO_OE_N & (hoe ? hv : ~hv));
   initial {SCK, CS_N} = 2'b01;
   // One SCK period; read lanes are taken at the rise, single mode on IO1
   task automatic clk(input logic [3:0] v, input logic drv, input int w);
      {hv, hoe} = {drv ? v : hv, drv};
      #24 rx = (rx << w) | 128'(w == 1 ? {3'h0, IO_IN[1]} : IO_IN & (w == 2 ? 4'h3 : 4'hf));
      SCK = 1'b1;
      #24 SCK = 1'b0;
   endtask
   // Opcode, then address, dummy and mode clocks of each kind, then nb bytes in
   task automatic frame(input logic [7:0] opc, input logic [23:0] a, input int nb);
      logic [63:0] v;
      int w;
      int n;
      w = (opc == 8'h92) ? 2 : (opc == 8'h94) ? 4 : 1;
      n = (opc == 8'h9f) ? 0 : (opc == 8'h90) ? 24 : (opc == 8'h92) ? 16 : (opc == 8'h94) ? 12 : 32;
      v = (w == 2) ? {a, 8'hf0, 32'h0} : (w == 4) ? {16'h0, a, 8'hf0, 16'h0} : {a, 40'h0};
      CS_N = 1'b0;
      for (int i = 7; i >= 0; i--) clk({3'h0, opc[i]}, 1'b1, 1);
      for (int i = 0; i < n; i++)
      begin
         clk(4'(v[63 -: 4] >> (4 - w)), 1'b1, w);
         v = v << w;
      end
      rx = '0;
      for (int i = 0; i < 8 * nb / w; i++) clk(4'h0, 1'b0, w);
      #10 {CS_N, hoe} = 2'b10;
   endtask
endmodule

// File: dv/testbench.sv
// Bench for the identification readout engine, driven by the SPI host model.
// Assumes the host's 48 ns link clock, unrelated in phase to the 25 ns MCLK.
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fail_count++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module testbench;
   typedef struct {logic [7:0] opc; logic [23:0] a; int nb;} sfi_row_s;
   localparam logic [7:0] MFR = 8'ha7; // Identity values are arbitrary
   localparam logic [7:0] DEV = 8'h3c;
   localparam logic [63:0] UID = 64'hf1e2d3c4b5a69788;
   localparam logic [127:0] TBL = {56'hff000080040100, MFR, 64'hff00010150444653};
   logic MCLK = 1'b0;
   logic RESET = 1'b1;
   logic SCK, CS_N, ID_ACTIVE, CMD_STROBE, CMD_KNOWN;
   logic [3:0] IO_IN, IO_OUT, IO_OE_N;
   logic [7:0] CMD_CODE;
   logic [127:0] e;
   int fail_count = 0;
   int n_tests = 0;
   int n_strobe = 0;
   int n_act = 0;
   // Ordinary readouts, upper table address kept zero; bytes expected come from exp_byte
   sfi_row_s rows [10] = '{'{8'h90, 24'h0, 4}, '{8'h90, 24'h1, 3}, '{8'h92, 24'h0, 4},
      '{8'h92, 24'h1, 2}, '{8'h94, 24'h0, 4}, '{8'h94, 24'h1, 3}, '{8'h4b, 24'h0, 10},
      '{8'h9f, 24'h0, 4}, '{8'h5a, 24'h0, 16}, '{8'h5a, 24'hfe, 4}};
   sfi_id_reader #(.MFR_ID(MFR), .DEV_ID(DEV), .MEM_TYPE(8'h62), .CAPACITY(8'h19),
      .UNIQUE_ID(UID)) uut (.MCLK, .RESET, .SCK, .CS_N, .IO_IN, .IO_OUT, .IO_OE_N,
      .ID_ACTIVE, .CMD_STROBE, .CMD_CODE, .CMD_KNOWN);
   sfi_host host (.SCK, .CS_N, .IO_IN, .IO_OUT, .IO_OE_N);
   // Byte i of a readout; table index wraps at 256
   function automatic logic [7:0] exp_byte(input logic [7:0] opc, input logic [23:0] a,
      input int i);
      logic [7:0] k;
      k = 8'(a[7:0] + i);
      case (opc)
         8'h4b: return UID[8 * (7 - i % 8) +: 8];
         8'h9f: return (i == 0) ? MFR : (i == 1) ? 8'h62 : (i == 2) ? 8'h19 : 8'hff;
         8'h5a: return (k < 8'h10) ? TBL[8 * k +: 8] : 8'hff;
         default: return (a[0] ^ i[0]) ? DEV : MFR;
      endcase
   endfunction
   // Opcode report after the frame has closed
   task rep(input logic [7:0] c, input logic k);
      repeat (8) @(posedge MCLK);
      `CHK({CMD_CODE, CMD_KNOWN, ID_ACTIVE}, {c, k, 1'b0})
   endtask
   task end_of_test;
      if (fail_count == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial forever #12.5 MCLK = ~MCLK;
   always @(posedge MCLK) n_strobe += int'(CMD_STROBE === 1'b1);
   always @(posedge MCLK) n_act += int'(ID_ACTIVE === 1'b1);
   // Watchdog, far beyond the roughly 36 us the frames need
   initial
   begin
      #500000 fail_count++;
      end_of_test();
   end
   initial
   begin
      repeat (8) @(posedge MCLK);
      #2 RESET = 1'b0;
      foreach (rows[r])
      begin
         @(posedge MCLK);
         #2 host.frame(rows[r].opc, rows[r].a, rows[r].nb);
         e = '0;
         for (int i = 0; i < rows[r].nb; i++) e = (e << 8) | 128'(exp_byte(rows[r].opc, rows[r].a, i));
         `CHK(host.rx, e)
         rep(rows[r].opc, 1'b1);
      end
      // Unknown opcode: lanes stay released, so the flipped idle level reads back
      #2 host.frame(8'h03, 24'h0, 1);
      `CHK(host.rx, 128'hff)
      rep(8'h03, 1'b0);
      `CHK(n_strobe, 11)
      `CHK(n_act != 0, 1'b1)
      // Reset in mid-run clears the report
      @(posedge MCLK);
      #2 RESET = 1'b1;
      @(posedge MCLK);
      `CHK({CMD_CODE, CMD_KNOWN, CMD_STROBE}, 10'h000)
      end_of_test();
   end
endmodule
